// file: afidc_top.sv
// How it works
// RULE1: level enable raises interrupt above threshold
// RULE2: level condition is count strictly above threshold
// RULE3: dma request while enabled and fifo nonempty
// RULE4: sixteen-bit compare value checked per output word
// RULE5: each satisfying word bumps the match counter
// RULE6: flag sets when counter reaches limit plus one
// RULE7: flag holds until software writes one
// RULE8: direction bit picks less or greater-equal
// RULE9: flag with irq enable raises interrupt
// RULE10: comparator idle while its enable is zero
// RULE11: data read pops; empty read repeats last
// RULE12: clearing run empties fifo and stops sampling
// RULE13: counter clears on disable, flag and reset
// RULE14: both interrupts are level, on one line
//
// service logic around the converter sample fifo: registers, level irq, dma request, comparator
// assumes samples and bus come from logic on clk_in; dma reads the data word over this bus
`timescale 1ns/1ps
module afidc_top
   import afidc_pkg::*;
#(
   parameter int FIFO_DEPTH = AFIDC_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // register port
   input wire logic [AFIDC_ADDR_W-1:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // converter core side
   input wire logic [AFIDC_DATA_W-1:0] sample_in,
   input wire logic sample_valid_in,
   output logic converter_run_out,
   // dma and interrupt
   output logic dma_req_out,
   output logic irq_out
);
   localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

   typedef struct packed {
      logic run;                          // converter running
      logic lvl_en;                       // fifo level irq enable
      logic [AFIDC_THR_W-1:0] thr;        // fifo threshold level
      logic dma_en;                       // dma receive enable
      logic [AFIDC_DATA_W-1:0] cmp_val;   // compare value
      logic [AFIDC_LIMIT_W-1:0] limit;    // match count limit
      logic flag;                         // compare hit flag
      logic dir;                          // compare direction
      logic cmp_ie;                       // compare irq enable
      logic cmp_en;                       // comparator enable
      logic [AFIDC_LIMIT_W:0] match_cnt;  // one bit wider; clears instead of reaching limit plus one
      logic [AFIDC_STS_W-1:0] sts;        // sticky event status
      logic [AFIDC_STS_W-1:0] mask;       // event mask
      logic lvl_prev;                     // level condition last cycle
      logic [AFIDC_DATA_W-1:0] last_word; // repeated on empty reads
      logic [31:0] rdata;                 // read data register
      logic dma_req;
      logic irq;
   } afidc_state_t;

   afidc_state_t s_r, s_nxt;
   afidc_fifo_if #(.W(AFIDC_DATA_W), .CW(CNT_W)) fq ();

   logic rd_data;     // read of the data word
   logic pop;         // word leaves the fifo
   logic lvl_cond;    // count above threshold
   logic hit;         // head satisfies the compare direction
   logic cnt_match;   // counter reaches limit plus one on this hit
   logic flag_set;
   logic [AFIDC_STS_W-1:0] events;
   logic [AFIDC_LIMIT_W:0] cnt_inc;

   // the fifo itself
   afidc_fifo #(.W(AFIDC_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .f(fq.fifo)
   );

   // fifo drive; samples are dropped while stopped or full
   assign fq.push = sample_valid_in && s_r.run; // RULE12
   assign fq.push_data = sample_in;
   assign fq.pop = pop;
   assign fq.flush = !s_r.run; // RULE12

   // outputs straight from flip-flops
   assign rdata_out = s_r.rdata;
   assign converter_run_out = s_r.run;
   assign dma_req_out = s_r.dma_req;
   assign irq_out = s_r.irq;

   // decode, comparator and register updates
   always_comb begin
      s_nxt = s_r;
      rd_data = rd_in && (addr_in == AFIDC_OFS_DATA);
      pop = rd_data && !fq.empty; // RULE11
      lvl_cond = fq.count > CNT_W'(s_r.thr); // RULE2
      // unsigned compare; less-than when dir is zero
      hit = s_r.dir ? (fq.head >= s_r.cmp_val) : (fq.head < s_r.cmp_val); // RULE4 RULE8
      cnt_inc = s_r.match_cnt + 1'b1;
      cnt_match = (cnt_inc == ({1'b0, s_r.limit} + 1'b1)); // RULE6
      flag_set = 1'b0;

      // comparator counts only words that really leave the fifo
      if (!s_r.cmp_en) begin
         s_nxt.match_cnt = '0; // RULE10 RULE13
      end else if (pop && hit) begin
         if (cnt_match) begin
            flag_set = 1'b1; // RULE6
            s_nxt.match_cnt = '0; // RULE13
         end else begin
            s_nxt.match_cnt = cnt_inc; // RULE5
         end
      end

      if (pop) begin
         s_nxt.last_word = fq.head;
      end

      // register writes
      if (wr_in) begin
         unique case (addr_in)
            AFIDC_OFS_RUN: begin
               s_nxt.run = wdata_in[AFIDC_RUN_BIT];
            end
            AFIDC_OFS_FIFO_IRQ: begin
               s_nxt.lvl_en = wdata_in[AFIDC_LVL_EN_BIT];
               s_nxt.thr = wdata_in[AFIDC_THR_LSB +: AFIDC_THR_W];
            end
            AFIDC_OFS_DMA: begin
               s_nxt.dma_en = wdata_in[AFIDC_DMA_EN_BIT];
            end
            AFIDC_OFS_CMP0: begin
               s_nxt.cmp_val = wdata_in[AFIDC_CMP_VAL_LSB +: AFIDC_DATA_W];
               s_nxt.limit = wdata_in[AFIDC_CMP_LIMIT_LSB +: AFIDC_LIMIT_W];
               s_nxt.dir = wdata_in[AFIDC_CMP_DIR_BIT];
               s_nxt.cmp_ie = wdata_in[AFIDC_CMP_IE_BIT];
               s_nxt.cmp_en = wdata_in[AFIDC_CMP_EN_BIT];
               // write one clears; zero leaves the flag alone
               if (wdata_in[AFIDC_CMP_FLAG_BIT]) begin
                  s_nxt.flag = 1'b0; // RULE7
               end
            end
            AFIDC_OFS_IRQ_MASK: begin
               s_nxt.mask = wdata_in[AFIDC_STS_W-1:0];
            end
            default: begin
               // other offsets are read-only or unmapped
            end
         endcase
      end
      // a hit in the clearing cycle is not lost
      if (flag_set) begin
         s_nxt.flag = 1'b1; // RULE6 RULE7
      end

      // read data, only in the cycle after the strobe
      s_nxt.rdata = AFIDC_REG_RESET;
      if (rd_in) begin
         unique case (addr_in)
            AFIDC_OFS_DATA: begin
               s_nxt.rdata[AFIDC_DATA_W-1:0] = fq.empty ? s_r.last_word : fq.head; // RULE11
            end
            AFIDC_OFS_RUN: begin
               s_nxt.rdata[AFIDC_RUN_BIT] = s_r.run;
            end
            AFIDC_OFS_FIFO_IRQ: begin
               s_nxt.rdata[AFIDC_LVL_EN_BIT] = s_r.lvl_en;
               s_nxt.rdata[AFIDC_THR_LSB +: AFIDC_THR_W] = s_r.thr;
            end
            AFIDC_OFS_DMA: begin
               s_nxt.rdata[AFIDC_DMA_EN_BIT] = s_r.dma_en;
            end
            AFIDC_OFS_CMP0: begin
               s_nxt.rdata[AFIDC_CMP_VAL_LSB +: AFIDC_DATA_W] = s_r.cmp_val;
               s_nxt.rdata[AFIDC_CMP_LIMIT_LSB +: AFIDC_LIMIT_W] = s_r.limit;
               s_nxt.rdata[AFIDC_CMP_FLAG_BIT] = s_r.flag;
               s_nxt.rdata[AFIDC_CMP_DIR_BIT] = s_r.dir;
               s_nxt.rdata[AFIDC_CMP_IE_BIT] = s_r.cmp_ie;
               s_nxt.rdata[AFIDC_CMP_EN_BIT] = s_r.cmp_en;
            end
            AFIDC_OFS_IRQ_STS: begin
               s_nxt.rdata[AFIDC_STS_W-1:0] = s_r.sts;
            end
            AFIDC_OFS_IRQ_MASK: begin
               s_nxt.rdata[AFIDC_STS_W-1:0] = s_r.mask;
            end
            default: begin
               // unmapped reads return zero
            end
         endcase
      end

      // sticky status: read clears, a new event wins
      events = '0;
      events[AFIDC_STS_LEVEL_BIT] = lvl_cond && !s_r.lvl_prev;
      events[AFIDC_STS_CMP_BIT] = flag_set;
      s_nxt.lvl_prev = lvl_cond;
      s_nxt.sts = ((rd_in && addr_in == AFIDC_OFS_IRQ_STS) ? '0 : s_r.sts) | events;

      // dma request is a level while data waits
      s_nxt.dma_req = s_r.dma_en && !fq.empty; // RULE3
      // one level interrupt line from all sources
      s_nxt.irq = (s_r.lvl_en && lvl_cond) || (s_r.cmp_ie && s_r.flag) || (|(s_r.sts & s_r.mask)); // RULE1 RULE9 RULE14
   end

   // state register
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_r <= '0; // RULE13
      end else begin
         s_r <= s_nxt;
      end
   end

   // checks on the logic above
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   lvl_irq_a: assert property ((s_r.lvl_en && lvl_cond) |=> irq_out) // RULE1
      else $error("level interrupt missing above threshold");
   lvl_strict_a: assert property ($rose(s_r.sts[AFIDC_STS_LEVEL_BIT]) |-> $past(fq.count) > CNT_W'($past(s_r.thr))) // RULE2
      else $error("level event without count above threshold");
   dma_level_a: assert property (1'b1 |=> (dma_req_out == $past(s_r.dma_en && !fq.empty))) // RULE3
      else $error("dma request does not follow enable and data");
   flag_set_a: assert property ((s_r.cmp_en && pop && hit && cnt_match && !s_r.flag) |=> s_r.flag) // RULE6
      else $error("compare flag not set on final match");
   cnt_step_a: assert property ((s_r.cmp_en && pop && hit && !cnt_match) |=> s_r.match_cnt == $past(s_r.match_cnt) + 1'b1) // RULE5
      else $error("match counter did not step");
   flag_hold_a: assert property ((s_r.flag && !(wr_in && addr_in == AFIDC_OFS_CMP0 && wdata_in[AFIDC_CMP_FLAG_BIT])) |=> s_r.flag) // RULE7
      else $error("compare flag dropped without write one");
   cmp_idle_a: assert property ((!s_r.cmp_en && !s_r.flag) |=> !s_r.flag) // RULE10
      else $error("flag set while comparator disabled");
   cmp_irq_a: assert property ((s_r.flag && s_r.cmp_ie) |=> irq_out) // RULE9
      else $error("compare interrupt missing");
   flush_a: assert property (!s_r.run |=> fq.count == '0) // RULE12
      else $error("fifo not emptied while stopped");
   empty_rd_a: assert property ((rd_data && fq.empty) |=> rdata_out == {16'h0000, $past(s_r.last_word)}) // RULE11
      else $error("empty read did not repeat last word");
   cnt_clr_a: assert property (!s_r.cmp_en |=> s_r.match_cnt == '0) // RULE13
      else $error("match counter not cleared when disabled");
endmodule

// file: afidc_pkg.sv
// package of constants for the converter fifo service block
// assumes a 32-bit register port with byte-free word decode
package afidc_pkg;
   // widths and depths
   localparam int AFIDC_DATA_W = 16;
   localparam int AFIDC_FIFO_DEPTH = 8;
   localparam int AFIDC_ADDR_W = 8;
   localparam int AFIDC_LIMIT_W = 4;
   localparam int AFIDC_THR_W = 3;
   localparam int AFIDC_STS_W = 2;
   // register offsets (byte addresses)
   localparam logic [7:0] AFIDC_OFS_DATA = 8'h00;
   localparam logic [7:0] AFIDC_OFS_RUN = 8'h04;
   localparam logic [7:0] AFIDC_OFS_FIFO_IRQ = 8'h10;
   localparam logic [7:0] AFIDC_OFS_DMA = 8'h14;
   localparam logic [7:0] AFIDC_OFS_CMP0 = 8'h18;
   localparam logic [7:0] AFIDC_OFS_IRQ_STS = 8'h20;
   localparam logic [7:0] AFIDC_OFS_IRQ_MASK = 8'h24;
   // field positions
   localparam int AFIDC_RUN_BIT = 0;
   localparam int AFIDC_LVL_EN_BIT = 31;
   localparam int AFIDC_THR_LSB = 0;
   localparam int AFIDC_DMA_EN_BIT = 0;
   localparam int AFIDC_CMP_VAL_LSB = 16;
   localparam int AFIDC_CMP_LIMIT_LSB = 8;
   localparam int AFIDC_CMP_FLAG_BIT = 7;
   localparam int AFIDC_CMP_DIR_BIT = 2;
   localparam int AFIDC_CMP_IE_BIT = 1;
   localparam int AFIDC_CMP_EN_BIT = 0;
   localparam int AFIDC_STS_LEVEL_BIT = 0;
   localparam int AFIDC_STS_CMP_BIT = 1;
   // reset values
   localparam logic [31:0] AFIDC_REG_RESET = 32'h0000_0000;
endpackage

// file: afidc_fifo_if.sv
// carrier between the service logic and its sample fifo
// assumes both ends share one clock
`timescale 1ns/1ps
interface afidc_fifo_if #(parameter int W = 16, parameter int CW = 4);
   logic push;          // write one word
   logic [W-1:0] push_data;
   logic pop;           // drop the head word
   logic flush;         // empty the fifo now
   logic [W-1:0] head;  // oldest word
   logic [CW-1:0] count; // words held
   logic empty;
   logic full;
   modport fifo (input push, push_data, pop, flush, output head, count, empty, full);
   modport user (output push, push_data, pop, flush, input head, count, empty, full);
endinterface

// file: afidc_fifo.sv
// sample fifo in flip-flops, indexed by read and write pointers
// assumes the user never pops when empty; pushes into a full fifo are dropped
`timescale 1ns/1ps
module afidc_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // fifo side of the carrier
   afidc_fifo_if.fifo f
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem; // storage
      logic [AW-1:0] wp;            // write index
      logic [AW-1:0] rp;            // read index
      logic [CW-1:0] cnt;           // fill level
   } afidc_fifo_state_t;

   afidc_fifo_state_t s_r, s_nxt;
   logic push_ok;
   logic pop_ok;

   // outputs straight from state
   assign f.head = s_r.mem[s_r.rp];
   assign f.count = s_r.cnt;
   assign f.empty = (s_r.cnt == '0);
   assign f.full = (s_r.cnt == CW'(DEPTH));

   // next state; flush wins over everything
   always_comb begin
      s_nxt = s_r;
      push_ok = f.push && !f.full;
      pop_ok = f.pop && !f.empty;
      if (push_ok) begin
         s_nxt.mem[s_r.wp] = f.push_data;
         s_nxt.wp = (s_r.wp == LAST) ? '0 : s_r.wp + 1'b1;
      end
      if (pop_ok) begin
         s_nxt.rp = (s_r.rp == LAST) ? '0 : s_r.rp + 1'b1;
      end
      // count moves only when exactly one side acts
      if (push_ok && !pop_ok) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop_ok && !push_ok) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
      if (f.flush) begin
         s_nxt.wp = '0;
         s_nxt.rp = '0;
         s_nxt.cnt = '0;
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// file: afidc_dma_model.sv
// dma controller stand-in: reads the data word while asked
// assumes the bench routes its read strobe onto the port
`timescale 1ns/1ps
module afidc_dma_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // bench control
   input wire logic on_in,
   input wire logic slow_in,
   // device side
   input wire logic dma_req_in,
   input wire logic [31:0] rdata_in,
   output logic rd_out,
   output logic got_out,
   output logic [15:0] word_out
);
   logic pend; // read answer due next cycle
   int gap; // cycles left before the request is trusted
   // one read, then a pause: the request lags the fifo by a cycle
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_out <= 1'b0;
         pend <= 1'b0;
         got_out <= 1'b0;
         gap <= 0;
      end else begin
         pend <= rd_out;
         got_out <= pend;
         word_out <= rdata_in[15:0];
         rd_out <= 1'b0;
         if (gap > 0) begin
            gap <= gap - 1;
         end else if (rd_out) begin
            gap <= slow_in ? 5 : 1;
         end else if (on_in && dma_req_in) begin
            rd_out <= 1'b1;
         end
      end
   end
endmodule

// file: tb.sv
// bench: register port driver, sample source and reference model
// assumes the service block with its default fifo depth
`timescale 1ns/1ps
module tb import afidc_pkg::*;;
   logic clk_in, reset_n_in, tb_wr, tb_rd, svalid, dma_on, dma_slow, dma_rd, got;
   logic [7:0] tb_addr;
   logic [31:0] wdata, rdata_out;
   logic [15:0] sample, word;
   logic irq_out, dma_req_out, run_out;
   logic [31:0] seed = 32'h0001_10ca; // fixed seed
   logic [7:0] ofs[7] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h3c};
   logic [15:0] cv[6] = '{16'h7fff, 16'h8000, 16'h0000, 16'hffff, 16'h8001, 16'h7ffe};
   int miscompares = 0;
   int n_compared = 0;
   // reference state
   int q[$];
   int last_w, thr, val, lim, cnt;
   bit run, lvl_en, dma_en, flag, dir, ie, cen;
   bit [1:0] sts, mask;
   afidc_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .addr_in(dma_rd ? AFIDC_OFS_DATA : tb_addr), .wdata_in(wdata), .wr_in(tb_wr),
      .rd_in(tb_rd | dma_rd), .rdata_out(rdata_out), .sample_in(sample), .sample_valid_in(svalid),
      .converter_run_out(run_out), .dma_req_out(dma_req_out), .irq_out(irq_out));
   afidc_dma_model dma (.clk_in(clk_in), .reset_n_in(reset_n_in), .on_in(dma_on), .slow_in(dma_slow),
      .dma_req_in(dma_req_out), .rdata_in(rdata_out), .rd_out(dma_rd), .got_out(got), .word_out(word));
   // free-running clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // reference pop: empty repeats the last word
   function automatic int ref_pop();
      int w;
      if (q.size() == 0) return last_w;
      w = q.pop_front();
      last_w = w;
      if (cen && (dir ? w >= val : w < val)) cnt++;
      if (cnt == lim + 1) begin
         flag = 1'b1;
         sts[1] = 1'b1;
         cnt = 0;
      end
      return w;
   endfunction
   function automatic bit irq_e();
      return (lvl_en && q.size() > thr) || (ie && flag) || (sts & mask) != 2'b00;
   endfunction
   function automatic logic [31:0] cw(int v, int l, bit f, bit d, bit i, bit e);
      return {v[15:0], 4'h0, l[3:0], f, 4'h0, d, i, e};
   endfunction
   function automatic logic [31:0] reg_e(logic [7:0] a);
      case (a)
         AFIDC_OFS_RUN: return {31'h0, run};
         AFIDC_OFS_FIFO_IRQ: return {lvl_en, 28'h0, thr[2:0]};
         AFIDC_OFS_DMA: return {31'h0, dma_en};
         AFIDC_OFS_CMP0: return cw(val, lim, flag, dir, ie, cen);
         AFIDC_OFS_IRQ_STS: return {30'h0, sts};
         AFIDC_OFS_IRQ_MASK: return {30'h0, mask};
         default: return 32'h0;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      n_compared++;
      if (got_v !== exp_v) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      tb_addr <= a;
      wdata <= d;
      tb_wr <= 1'b1;
      @(posedge clk_in);
      tb_wr <= 1'b0;
      case (a)
         AFIDC_OFS_RUN: begin
            run = d[0];
            if (!run) q.delete();
         end
         AFIDC_OFS_FIFO_IRQ: begin
            lvl_en = d[31];
            thr = d[2:0];
         end
         AFIDC_OFS_DMA: dma_en = d[0];
         AFIDC_OFS_CMP0: begin
            val = d[31:16];
            lim = d[11:8];
            dir = d[2];
            ie = d[1];
            cen = d[0];
            if (d[7]) flag = 1'b0;
            if (!cen) cnt = 0;
         end
         AFIDC_OFS_IRQ_MASK: mask = d[1:0];
         default: ;
      endcase
   endtask
   // status bit0 timing is left open, so only bit1 is judged there
   task automatic rd(input logic [7:0] a);
      logic [31:0] e, c;
      e = (a == AFIDC_OFS_DATA) ? ref_pop() : reg_e(a);
      c = (a == AFIDC_OFS_DATA) ? 32'h0000_ffff : (a == AFIDC_OFS_IRQ_STS) ? 32'h0000_0002 : 32'hffff_ffff;
      @(posedge clk_in);
      tb_addr <= a;
      tb_rd <= 1'b1;
      @(posedge clk_in);
      tb_rd <= 1'b0;
      if (a == AFIDC_OFS_IRQ_STS) sts = 2'b00;
      #1;
      chk(rdata_out & c, e & c);
   endtask
   task automatic push_v(input logic [15:0] w);
      @(posedge clk_in);
      sample <= w;
      svalid <= 1'b1;
      @(posedge clk_in);
      svalid <= 1'b0;
      if (run && q.size() < AFIDC_FIFO_DEPTH) q.push_back(int'(w));
   endtask
   task automatic push(input int n);
      logic [31:0] r;
      repeat (n) begin
         r = xs();
         push_v(r[15:0]);
      end
   endtask
   // outputs are registered, so let two edges land first
   task automatic outs();
      repeat (2) @(posedge clk_in);
      #1;
      chk(irq_out, irq_e());
      chk(dma_req_out, dma_en && q.size() > 0);
   endtask
   // words taken by the dma stand-in
   always @(posedge clk_in) if (got) chk({16'h0, word}, ref_pop());
   task automatic end_sim();
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #500_000;
      miscompares++;
      end_sim();
   end
   initial begin
      logic [31:0] r;
      tb_addr = 8'h00;
      wdata = 32'h0;
      tb_wr = 1'b0;
      tb_rd = 1'b0;
      sample = 16'h0;
      svalid = 1'b0;
      dma_on = 1'b0;
      dma_slow = 1'b0;
      reset_n_in = 1'b0;
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      // reset values, unmapped place last
      foreach (ofs[i]) rd(ofs[i]);
      outs();
      // random fields read back, read-only status write ignored
      for (int i = 1; i < 6; i++) begin
         r = xs();
         wr(ofs[i], r & 32'hffff_ff7e);
         rd(ofs[i]);
         wr(ofs[i], 32'h0);
      end
      // each threshold: at it no irq, one above raises it
      for (int t = 0; t < 8; t++) begin
         wr(AFIDC_OFS_RUN, 32'h0);
         wr(AFIDC_OFS_RUN, 32'h1);
         wr(AFIDC_OFS_FIFO_IRQ, 32'h8000_0000 | t);
         push(t);
         outs();
         push(1);
         outs();
      end
      push(1);
      wr(AFIDC_OFS_FIFO_IRQ, 32'h0000_0003);
      outs();
      repeat (9) rd(AFIDC_OFS_DATA);
      // stopping the converter empties the fifo and refuses samples
      wr(AFIDC_OFS_DMA, 32'h1);
      push(3);
      wr(AFIDC_OFS_RUN, 32'h0);
      push(2);
      outs();
      chk(run_out, 1'b0);
      wr(AFIDC_OFS_RUN, 32'h1);
      outs();
      chk(run_out, 1'b1);
      // dma drains promptly, then slowly
      for (int s = 0; s < 2; s++) begin
         dma_slow <= s[0];
         push(3 + s);
         outs();
         dma_on <= 1'b1;
         for (int k = 0; k < 100 && q.size() > 0; k++) @(posedge clk_in);
         dma_on <= 1'b0;
         outs();
      end
      wr(AFIDC_OFS_DMA, 32'h0);
      push(2);
      outs();
      repeat (2) rd(AFIDC_OFS_DATA);
      // both directions against boundary words, third hit sets the flag
      for (int d = 0; d < 2; d++) begin
         wr(AFIDC_OFS_CMP0, cw(32'h0000_8000, 2, 1, d[0], 1, 1));
         foreach (cv[i]) push_v(cv[i]);
         foreach (cv[i]) begin
            rd(AFIDC_OFS_DATA);
            rd(AFIDC_OFS_CMP0);
            outs();
         end
      end
      wr(AFIDC_OFS_CMP0, cw(32'h0000_8000, 2, 0, 1, 1, 1));
      rd(AFIDC_OFS_CMP0);
      wr(AFIDC_OFS_CMP0, cw(32'h0000_8000, 2, 1, 1, 1, 1));
      rd(AFIDC_OFS_CMP0);
      // disabling drops partial counts and ignores words
      repeat (6) push_v(16'hc000);
      repeat (2) rd(AFIDC_OFS_DATA);
      wr(AFIDC_OFS_CMP0, cw(32'h0000_8000, 2, 0, 1, 1, 0));
      rd(AFIDC_OFS_DATA);
      wr(AFIDC_OFS_CMP0, cw(32'h0000_8000, 2, 0, 1, 1, 1));
      repeat (2) rd(AFIDC_OFS_DATA);
      rd(AFIDC_OFS_CMP0);
      rd(AFIDC_OFS_DATA);
      rd(AFIDC_OFS_CMP0);
      // status, mask and a flag without its interrupt enable
      rd(AFIDC_OFS_IRQ_STS);
      wr(AFIDC_OFS_IRQ_MASK, 32'h0000_0002);
      wr(AFIDC_OFS_CMP0, cw(32'h0000_8000, 0, 1, 1, 0, 1));
      push_v(16'hffff);
      rd(AFIDC_OFS_DATA);
      outs();
      rd(AFIDC_OFS_IRQ_STS);
      outs();
      end_sim();
   end
endmodule
